// file: hdl/line_startup.sv
// start-up signal sequencing for one end of a 2-wire line transceiver, with apb registers
// Operation
// - framed start-up signal always carries the normal frame word, never the inverted one.
// - full-rate signal fills overhead bits as in normal operation.
// - payload stays at start-up value until both readiness bits show transparency, except loopback.
// - held payload is all ONE at network termination, all ZERO at line termination.
// - full-rate signal, once started, runs until the transceiver is turned off.
// - network termination goes active on terminal ready or far full-rate signal, whichever first.
// - received loop-only activation bit is used only when that option is built in.
// - network termination goes transparent only when operational, far ready ONE, no-teardown ONE, except loopback.
// - each change of transmitted readiness bit repeats in at least three multiframes.
//
// The address map and register access over APB were left to the implementer.
`default_nettype none
module line_startup #(
    parameter bit IS_NT = 1'b1,
    parameter bit LOOP_ONLY_OPT = 1'b0,
    parameter int READY_REPEAT = line_startup_pkg::ready_repeat_multiframes
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [line_startup_pkg::addr_w-1:0] paddr,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output var logic pready,
    output var logic pslverr,
    input wire logic frame_start,
    input wire logic multiframe_start,
    input wire line_startup_pkg::rx_status_t rx,
    input wire logic terminal_ready_indication,
    output var line_startup_pkg::tx_ctrl_t tx,
    output var logic active
);
    initial begin
        if (READY_REPEAT < 3) begin
            $error("line_startup: READY_REPEAT below three multiframes");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser and apb registers

    logic term_meta;
    logic term_ready;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            term_meta <= 1'b0;
            term_ready <= 1'b0;
        end else begin
            term_meta <= terminal_ready_indication;
            term_ready <= term_meta;
        end
    end

    logic [2:0] ctrl;
    line_startup_pkg::startup_state_t state;
    logic apb_access;
    logic addr_ok;
    assign apb_access = psel && penable && !pready;
    assign addr_ok = (paddr == line_startup_pkg::ctrl_addr) || (paddr == line_startup_pkg::status_addr);

    // one wait state: pready is registered so every output stays a flop
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= apb_access;
            pslverr <= apb_access && !addr_ok;
            prdata <= 32'h0;
            if (apb_access && !pwrite && paddr == line_startup_pkg::ctrl_addr) begin
                prdata <= {29'h0, ctrl};
            end else if (apb_access && !pwrite && paddr == line_startup_pkg::status_addr) begin
                prdata[line_startup_pkg::status_state_pos +: 4] <= state;
                prdata[line_startup_pkg::status_live_pos] <= tx.payload_live;
                prdata[line_startup_pkg::status_tx_ready_pos] <= tx.layer2_ready_bit;
                prdata[line_startup_pkg::status_rx_ready_pos] <= rx.layer2_ready_bit;
                prdata[line_startup_pkg::status_oper_pos] <= rx.operational;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= line_startup_pkg::ctrl_reset;
        // the write lands at the edge that completes the transfer, when pready is seen high
        end else if (psel && penable && pready && pwrite && paddr == line_startup_pkg::ctrl_addr) begin
            ctrl <= pwdata[2:0];
        end
    end

    logic enable;
    logic sw_ready;
    logic loopback;
    assign enable = ctrl[line_startup_pkg::ctrl_enable_pos];
    assign sw_ready = ctrl[line_startup_pkg::ctrl_ready_pos];
    assign loopback = ctrl[line_startup_pkg::ctrl_loopback_pos];

    ////////////////////////////////////////////////////////////////////////////
    // start-up state machine

    logic loop_only_seen;
    logic go_active;
    line_startup_pkg::startup_state_t next_state;
    assign loop_only_seen = LOOP_ONLY_OPT && rx.loop_only_activation_bit;
    assign go_active = IS_NT ? (term_ready || rx.full_rate_seen || loop_only_seen) : rx.full_rate_seen;

    always_comb begin
        next_state = state;
        case (state)
            line_startup_pkg::st_off: begin
                if (enable) next_state = line_startup_pkg::st_framed;
            end
            line_startup_pkg::st_framed: begin
                if (rx.operational) next_state = line_startup_pkg::st_full_rate;
            end
            line_startup_pkg::st_full_rate: begin
                if (go_active) next_state = line_startup_pkg::st_active;
            end
            line_startup_pkg::st_active: begin
                next_state = line_startup_pkg::st_active;
            end
            default: begin
                next_state = line_startup_pkg::st_off;
            end
        endcase
        if (!enable) begin
            next_state = line_startup_pkg::st_off;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state <= line_startup_pkg::st_off;
            active <= 1'b0;
        end else begin
            state <= next_state;
            active <= (next_state == line_startup_pkg::st_active);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // readiness bit and per-frame transmit orders

    logic ready_req;
    logic ready_held;
    // for the network side the bit reflects the terminal as well as local software
    assign ready_req = (state == line_startup_pkg::st_active) && sw_ready && (!IS_NT || term_ready);

    repeat_hold #(
        .REPEAT(READY_REPEAT)
    ) u_ready_hold (
        .mclk(mclk),
        .rstn(rstn),
        .multiframe_start(multiframe_start),
        .req(ready_req),
        .held(ready_held)
    );

    logic transparent_ok;
    logic full_rate_now;
    assign full_rate_now = (state == line_startup_pkg::st_full_rate) || (state == line_startup_pkg::st_active);
    assign transparent_ok = (state == line_startup_pkg::st_active) && rx.operational && tx.layer2_ready_bit
        && rx.layer2_ready_bit && (!IS_NT || rx.no_teardown_bit);

    // orders change at frame starts and the ready bit at multiframe starts; turning off clears sending, full rate and live payload at once
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tx <= '0;
        end else begin
            if (!enable) begin
                tx.sending <= 1'b0;
                tx.full_rate <= 1'b0;
                tx.payload_live <= 1'b0;
            end else if (frame_start) begin
                tx.sending <= (state != line_startup_pkg::st_off);
                tx.full_rate <= full_rate_now || tx.full_rate;
                tx.inverted_frame_word <= multiframe_start && (full_rate_now || tx.full_rate);
                tx.overhead_normal <= full_rate_now || tx.full_rate;
                tx.payload_live <= full_rate_now && (loopback || transparent_ok);
                tx.payload_fill <= IS_NT;
            end
            if (multiframe_start) begin
                tx.layer2_ready_bit <= ready_held;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic [1:0] mf_since_change;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mf_since_change <= 2'h3;
        end else if (multiframe_start && tx.layer2_ready_bit != ready_held) begin
            mf_since_change <= 2'h0;
        end else if (multiframe_start && mf_since_change != 2'h3) begin
            mf_since_change <= mf_since_change + 2'h1;
        end
    end

    a_framed_word_normal: assert property (@(posedge mclk) disable iff (!rstn)
        frame_start && enable && state == line_startup_pkg::st_framed && !tx.full_rate |=> !tx.inverted_frame_word)
        else $error("inverted frame word during framed start-up");
    a_overhead_normal: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(tx.full_rate) |-> tx.overhead_normal)
        else $error("full-rate signal without normal overhead");
    a_payload_held: assert property (@(posedge mclk) disable iff (!rstn)
        frame_start && enable && !loopback && !(tx.layer2_ready_bit && rx.layer2_ready_bit) |=> !tx.payload_live)
        else $error("payload live before both readiness bits");
    a_fill_value: assert property (@(posedge mclk) disable iff (!rstn)
        tx.full_rate && !tx.payload_live ##1 tx.full_rate |-> tx.payload_fill == IS_NT)
        else $error("wrong held payload value");
    a_full_rate_holds: assert property (@(posedge mclk) disable iff (!rstn)
        tx.full_rate && enable ##1 enable |-> tx.full_rate)
        else $error("full-rate signal stopped while enabled");
    a_nt_active_first: assert property (@(posedge mclk) disable iff (!rstn)
        IS_NT && enable && state == line_startup_pkg::st_full_rate && (term_ready || rx.full_rate_seen)
        |=> state == line_startup_pkg::st_active ##0 active)
        else $error("network side did not go active");
    a_loop_only_ignored: assert property (@(posedge mclk) disable iff (!rstn)
        !LOOP_ONLY_OPT && state == line_startup_pkg::st_full_rate && !term_ready && !rx.full_rate_seen
        |=> state != line_startup_pkg::st_active)
        else $error("active without a valid cause");
    a_nt_teardown_block: assert property (@(posedge mclk) disable iff (!rstn)
        IS_NT && frame_start && !loopback && !(rx.no_teardown_bit && rx.operational) |=> !tx.payload_live)
        else $error("network side transparent without no-teardown or operational status");
    a_ready_repeat: assert property (@(posedge mclk) disable iff (!rstn)
        multiframe_start && tx.layer2_ready_bit != ready_held |-> mf_since_change >= 2'h2)
        else $error("readiness bit changed within three multiframes");
    a_payload_frame_edge: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(tx.payload_live) |-> $past(frame_start))
        else $error("payload went live away from a frame boundary");
endmodule : line_startup
`default_nettype wire

// file: hdl/line_startup_pkg.sv
// constants, states and carriers shared by the line start-up block
`default_nettype none
package line_startup_pkg;
    localparam int addr_w = 12;
    localparam logic [11:0] ctrl_addr = 12'h000;
    localparam logic [11:0] status_addr = 12'h004;
    localparam int ctrl_enable_pos = 0;
    localparam int ctrl_ready_pos = 1;
    localparam int ctrl_loopback_pos = 2;
    localparam logic [2:0] ctrl_reset = 3'h0;
    localparam int status_state_pos = 0;
    localparam int status_live_pos = 4;
    localparam int status_tx_ready_pos = 5;
    localparam int status_rx_ready_pos = 6;
    localparam int status_oper_pos = 7;
    localparam int ready_repeat_multiframes = 3;

    typedef enum logic [3:0] {
        st_off = 4'h1,
        st_framed = 4'h2,
        st_full_rate = 4'h4,
        st_active = 4'h8
    } startup_state_t;

    // per-frame indications from the receiver, same clock
    typedef struct packed {
        logic operational;
        logic full_rate_seen;
        logic layer2_ready_bit;
        logic no_teardown_bit;
        logic loop_only_activation_bit;
    } rx_status_t;

    // per-frame orders to the transmit framer, held for a whole frame except the ones that turning off clears at once
    typedef struct packed {
        logic sending;
        logic full_rate;
        logic inverted_frame_word;
        logic overhead_normal;
        logic payload_live;
        logic payload_fill;
        logic layer2_ready_bit;
    } tx_ctrl_t;
endpackage : line_startup_pkg
`default_nettype wire

// file: hdl/repeat_hold.sv
// holds a transmitted bit for a minimum number of multiframes after each change
`default_nettype none
module repeat_hold #(
    parameter int REPEAT = 3
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic multiframe_start,
    input wire logic req,
    output var logic held
);
    localparam int cnt_w = $clog2(REPEAT + 1);

    initial begin
        if (REPEAT < 1) begin
            $error("repeat_hold: REPEAT must be at least one");
        end
    end

    logic [cnt_w-1:0] cnt;

    // a change is only taken at a multiframe start and then kept for REPEAT multiframes
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            held <= 1'b0;
            cnt <= '0;
        end else if (multiframe_start) begin
            if (cnt != '0) begin
                cnt <= cnt - 1'b1;
            end else if (held != req) begin
                held <= req;
                cnt <= cnt_w'(REPEAT - 1);
            end
        end
    end
endmodule : repeat_hold
`default_nettype wire

// file: sim/far_end_model.sv
// far-end line transceiver model: frame timing and per-frame received status
`default_nettype none
module far_end_model (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [3:0] want,
    output var logic frame_start,
    output var logic multiframe_start,
    output var line_startup_pkg::rx_status_t rx
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] cnt;
    ////////////////////////////////////////////////////////////////
    // 8-cycle frames, 4 frames a multiframe: far shorter than the line, keeps the run quick
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 5'h00;
            rx <= '0;
        end else begin
            cnt <= cnt + 5'h01;
            // status only moves at frame ends; the loop-only bit is noise the block must not act on
            if (cnt[2:0] == 3'h7) rx <= {want, 1'($urandom)};
        end
    end
    // multiframe start always lands on a frame start
    assign frame_start = rstn && cnt[2:0] == 3'h0;
    assign multiframe_start = rstn && cnt == 5'h00;
endmodule : far_end_model
`default_nettype wire

// file: sim/line_startup_bench.sv
// self-checking bench for the line start-up block at the network termination end
`default_nettype none
module line_startup_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rstn, psel, penable, pwrite, term, pready, pslverr, frame_start, multiframe_start, active;
    logic live_q, fs_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] want;
    logic [32:0] expq[$];
    line_startup_pkg::rx_status_t rx;
    line_startup_pkg::tx_ctrl_t tx;
    int miscompares, samples_checked, n;
    ////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    line_startup #(.IS_NT(1'b1), .LOOP_ONLY_OPT(1'b0)) u_dut (.mclk(mclk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_start(frame_start), .multiframe_start(multiframe_start), .rx(rx),
        .terminal_ready_indication(term), .tx(tx), .active(active));
    far_end_model u_far (.mclk(mclk), .rstn(rstn), .want(want), .frame_start(frame_start),
        .multiframe_start(multiframe_start), .rx(rx));
    ////////////////////////////////////////////////////////////////
    task check(input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task give_verdict;
        $display("checks %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    // every transfer notes {pslverr, prdata} expected; the monitor below compares when pready comes
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp);
        @(posedge mclk);
        expq.push_back(exp);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // no assumed wait count: only the watchdog ends a stuck transfer
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wait_frames(input int f);
        repeat (f) begin
            do @(posedge mclk); while (!frame_start);
        end
        // one more edge: outputs launched at the frame edge are settled, stimulus stays on the edge
        @(posedge mclk);
    endtask : wait_frames
    ////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        if (psel && penable && pready === 1'b1) check({pslverr, prdata}, expq.pop_front());
        // held and live payload never share a frame
        if (rstn && tx.sending && tx.payload_live !== live_q && !fs_q) check(tx.payload_live, live_q);
        live_q = tx.payload_live;
        fs_q = frame_start;
    end
    initial begin
        #100000;
        miscompares++;
        give_verdict();
    end
    initial begin
        void'($urandom(21093));
        {rstn, psel, penable, pwrite, term, live_q, fs_q} = '0;
        {paddr, pwdata, want, miscompares, samples_checked} = '0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        apb(1'b0, line_startup_pkg::ctrl_addr, 32'h0, 33'h0);
        apb(1'b0, line_startup_pkg::status_addr, 32'h0, 33'h1);
        apb(1'b0, 12'h008, 32'h0, 33'h1_0000_0000);
        apb(1'b1, line_startup_pkg::status_addr, $urandom, 33'h0);
        apb(1'b0, line_startup_pkg::status_addr, 32'h0, 33'h1);
        $display("test registers done");
        apb(1'b1, line_startup_pkg::ctrl_addr, {29'($urandom), 3'h1}, 33'h0);
        wait_frames(1);
        for (n = 0; n < 5; n++) begin
            wait_frames(1);
            check({tx.sending, tx.full_rate, tx.inverted_frame_word}, 3'h4);
        end
        want <= 4'h8;
        wait_frames(2);
        check({tx.full_rate, tx.overhead_normal, tx.payload_fill, tx.payload_live}, 4'he);
        term <= 1'b1;
        wait_frames(1);
        check(active, 1'b1);
        $display("test full rate done");
        apb(1'b1, line_startup_pkg::ctrl_addr, 32'h3, 33'h0);
        for (n = 0; n < 200 && tx.layer2_ready_bit !== 1'b1; n++) @(posedge mclk);
        check(tx.layer2_ready_bit, 1'b1);
        want <= 4'hb;
        wait_frames(3);
        check(tx.payload_live, 1'b1);
        want <= 4'ha;
        wait_frames(2);
        check(tx.payload_live, 1'b0);
        apb(1'b1, line_startup_pkg::ctrl_addr, 32'h7, 33'h0);
        wait_frames(2);
        check(tx.payload_live, 1'b1);
        $display("test transparency done");
        // ready dropped, then asked for again at once: the new zero must still stand for the repeat span
        apb(1'b1, line_startup_pkg::ctrl_addr, 32'h1, 33'h0);
        for (n = 0; n < 200 && tx.layer2_ready_bit !== 1'b0; n++) @(posedge mclk);
        check(tx.layer2_ready_bit, 1'b0);
        apb(1'b1, line_startup_pkg::ctrl_addr, 32'h3, 33'h0);
        n = 0;
        repeat (4) begin
            do @(posedge mclk); while (!multiframe_start);
            @(posedge mclk);
            check(tx.inverted_frame_word, 1'b1);
            if (tx.layer2_ready_bit === 1'b0) n++;
        end
        check(n, line_startup_pkg::ready_repeat_multiframes - 1);
        check(tx.layer2_ready_bit, 1'b1);
        check({tx.sending, tx.full_rate}, 2'h3);
        apb(1'b1, line_startup_pkg::ctrl_addr, 32'h0, 33'h0);
        term <= 1'b0;
        repeat (2) @(posedge mclk);
        check({tx.sending, tx.full_rate, active}, 3'h0);
        $display("test turn off done");
        want <= 4'hc;
        apb(1'b1, line_startup_pkg::ctrl_addr, 32'h1, 33'h0);
        wait_frames(4);
        check({active, tx.full_rate}, 2'h3);
        $display("test far start done");
        give_verdict();
    end
endmodule : line_startup_bench
`default_nettype wire
